// ===== rtl/acq_regs.vh
// Purpose: Register map, field positions and reset values of the acquisition channel.
// Assumes: Byte addresses on a 6-bit register port, one 32-bit word per register.
// Notes: Decimation registers hold the factor N; the logic keeps N-1.
`ifndef ACQ_REGS_VH
`define ACQ_REGS_VH

// Register byte offsets.
`define REG_CTRL 6'h00
`define REG_TUNE 6'h04
`define REG_DEC1 6'h08
`define REG_DEC2 6'h0C
`define REG_STAT 6'h10
`define REG_COEF 6'h14
`define REG_TIME 6'h18
`define REG_LINK_HI 2'h2

// Control register fields.
`define CTRL_SRC_LO 0
`define CTRL_TRANS 2
`define CTRL_FMT16 3
`define CTRL_GO 4
`define CTRL_ARM 5

// Input source codes.
`define SRC_ADC0 2'h0
`define SRC_ADC1 2'h1
`define SRC_TEST 2'h2
`define SRC_LOOP 2'h3

// Status register fields.
`define STAT_OVF 0
`define STAT_BUSY 1
`define STAT_DONE 2
`define STAT_GREC 3
`define STAT_FILL_LO 16

// Link entry fields.
`define LINK_LEN_HI 23
`define LINK_GATE 24
`define LINK_META 25
`define LINK_LAST 26
`define LINK_NEXT_LO 28

// Reset values and limits.
`define CTRL_RST 32'h0000_0000
`define TUNE_RST 32'h0000_0000
`define DEC_RST_M1 8'h01
`define DEC_MIN 9'h002
`define DEC_MAX 9'h100
`define DEC_FIXED_M1 8'h01
`define LINK_RST 32'h0000_0000

// Filter weights, the memory bank and the metadata mark.
`define COEF_SHIFT 14
`define COEF_UNITY 16'h4000
`define COEF_DEFAULTS 128'h0C00_2400_4C00_7000_7000_4C00_2400_0C00
`define BANK_BYTES 64'h0000_0000_4000_0000
`define META_MARK 8'hA5

`endif

// ===== rtl/dec_stage.v
// Purpose: One integrate-and-dump decimation stage with a per-sample weight.
// Assumes: factor_m1 holds N-1 and is stable while a window runs.
// Notes: The window sum is scaled down by 2^8 so a 256 window of unity weights keeps full scale.
`timescale 1ns/100ps
`default_nettype none
`include "acq_regs.vh"
module dec_stage #(
   parameter W = 24
) (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Input samples
   input wire in_valid,
   input wire signed [W-1:0] in_i,
   input wire signed [W-1:0] in_q,
   // Settings
   input wire [7:0] factor_m1,
   input wire [15:0] coef,
   // Output samples
   output reg out_valid,
   output reg signed [W-1:0] out_i,
   output reg signed [W-1:0] out_q,
   output reg [7:0] phase
);
   localparam AW = W + 24;
   wire signed [W+15:0] prod_i;
   wire signed [W+15:0] prod_q;
   wire signed [AW-1:0] sum_i;
   wire signed [AW-1:0] sum_q;
   reg signed [AW-1:0] acc_i;
   reg signed [AW-1:0] acc_q;

   assign prod_i = in_i * $signed(coef);
   assign prod_q = in_q * $signed(coef);
   assign sum_i = acc_i + ($signed({{8{prod_i[W+15]}}, prod_i}) >>> `COEF_SHIFT);
   assign sum_q = acc_q + ($signed({{8{prod_q[W+15]}}, prod_q}) >>> `COEF_SHIFT);

   always @(posedge core_clk) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         out_i <= {W{1'b0}};
         out_q <= {W{1'b0}};
         acc_i <= {AW{1'b0}};
         acc_q <= {AW{1'b0}};
         phase <= 8'h00;
      end else begin
         out_valid <= 1'b0;
         if (in_valid) begin
            if (phase >= factor_m1) begin
               out_i <= sum_i[W+7:8];
               out_q <= sum_q[W+7:8];
               out_valid <= 1'b1;
               acc_i <= {AW{1'b0}};
               acc_q <= {AW{1'b0}};
               phase <= 8'h00;
            end else begin
               acc_i <= sum_i;
               acc_q <= sum_q;
               phase <= phase + 8'h01;
            end
         end
      end
   end
endmodule // dec_stage
`default_nettype wire

// ===== rtl/acq_channel.v
// Purpose: One acquisition channel: source select, downconverter, memory bank and DMA.
// Assumes: Converter samples arrive one per core_clk; timing bus pins are asynchronous.
// Notes: The bank is a scaled-down model of the full-size memory; BANK_AW sets its depth.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "acq_regs.vh"
module acq_channel #(
   parameter [15:0] CH_ID = 16'h0000,
   parameter ADC_W = 12,
   parameter BANK_AW = 10
) (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Register port
   input wire [5:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // Converter and loopback samples
   input wire [ADC_W-1:0] adc0_data,
   input wire [ADC_W-1:0] adc1_data,
   input wire [ADC_W-1:0] loop_data,
   // Timing bus
   input wire tb_sync,
   input wire tb_gate,
   // Downconverter output
   output wire ddc_valid,
   output wire [23:0] ddc_i,
   output wire [23:0] ddc_q,
   // DMA stream
   output reg [31:0] dma_data,
   output reg dma_valid,
   output reg dma_last,
   input wire dma_ready
);
   localparam LINKS = 4;
   localparam [BANK_AW:0] DEPTH = {1'b1, {BANK_AW{1'b0}}};
   localparam [2:0] D_IDLE = 3'h0;
   localparam [2:0] D_LOAD = 3'h1;
   localparam [2:0] D_WAIT = 3'h2;
   localparam [2:0] D_META = 3'h3;
   localparam [2:0] D_DATA = 3'h4;
   localparam [2:0] D_NEXT = 3'h5;

   // Register state.
   reg [1:0] src;
   reg trans;
   reg fmt16;
   reg [31:0] tune;
   reg [7:0] dec1_m1;
   reg [7:0] dec2_m1;
   reg [127:0] coef_flat;
   reg [31:0] link_mem [0:LINKS-1];
   integer k;

   // Synchronisers and timing.
   reg [ADC_W-1:0] adc0_meta;
   reg [ADC_W-1:0] adc0_sync;
   reg [ADC_W-1:0] adc1_meta;
   reg [ADC_W-1:0] adc1_sync;
   reg gate_meta;
   reg gate_sync;
   reg gate_d;
   reg sync_meta;
   reg sync_sync;
   reg sync_d;
   reg gate_fall_d;
   reg [31:0] ts;
   reg [ADC_W-1:0] test_cnt;
   reg [ADC_W-1:0] sample;

   // Mixer and stages.
   reg [31:0] nco_phase;
   reg signed [23:0] mix_i;
   reg signed [23:0] mix_q;
   wire signed [23:0] samp_ext;
   wire s1_valid;
   wire signed [23:0] s1_i;
   wire signed [23:0] s1_q;
   wire [7:0] s1_phase;
   wire s2_valid;
   wire signed [23:0] s2_i;
   wire signed [23:0] s2_q;

   // Bank and capture.
   reg [31:0] bank [0:(1<<BANK_AW)-1];
   reg [BANK_AW:0] wr_ptr;
   reg [BANK_AW:0] rd_ptr;
   reg pend;
   reg [31:0] pend_word;
   reg ovf;
   reg cap_open;
   reg cap_done;
   reg [23:0] gcount;
   reg [31:0] gts;
   reg grec;
   reg [23:0] grec_len;
   reg [31:0] grec_ts;
   wire [BANK_AW:0] fill;
   wire full;
   wire empty;
   wire cap_en;
   wire w_req;
   wire wr_fire;
   wire [31:0] w_word;
   wire [31:0] bank_wd;
   wire gate_rise;
   wire gate_fall;

   // DMA.
   reg [2:0] dstate;
   reg [1:0] link_idx;
   reg [31:0] cur_link;
   reg [23:0] xfer_len;
   reg [23:0] left;
   reg [31:0] meta_ts;
   reg [1:0] meta_cnt;
   reg grec_take;
   wire out_free;
   wire wr_ctrl;
   wire go;
   wire arm;
   wire ovf_clr;

   function [7:0] dec_clamp;
      input [8:0] n;
      reg [8:0] t;
      begin
         t = n - 9'h001;
         if (n < `DEC_MIN)
            dec_clamp = `DEC_RST_M1;
         else if (n > `DEC_MAX)
            dec_clamp = 8'hFF;
         else
            dec_clamp = t[7:0];
      end
   endfunction

   assign wr_ctrl = reg_wr && (reg_addr == `REG_CTRL);
   assign go = wr_ctrl && reg_wdata[`CTRL_GO];
   assign arm = wr_ctrl && reg_wdata[`CTRL_ARM];
   assign ovf_clr = reg_wr && (reg_addr == `REG_STAT) && reg_wdata[`STAT_OVF];

   // Register writes.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         src <= 2'h0;
         trans <= 1'b0;
         fmt16 <= 1'b0;
         tune <= `TUNE_RST;
         dec1_m1 <= `DEC_RST_M1;
         dec2_m1 <= `DEC_RST_M1;
         coef_flat <= `COEF_DEFAULTS;
         for (k = 0; k < LINKS; k = k + 1)
            link_mem[k] <= `LINK_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            `REG_CTRL: begin
               src <= reg_wdata[`CTRL_SRC_LO+1:`CTRL_SRC_LO];
               trans <= reg_wdata[`CTRL_TRANS];
               fmt16 <= reg_wdata[`CTRL_FMT16];
            end
            `REG_TUNE: tune <= reg_wdata;
            `REG_DEC1: dec1_m1 <= dec_clamp(reg_wdata[8:0]);
            `REG_DEC2: dec2_m1 <= dec_clamp(reg_wdata[8:0]);
            `REG_COEF: coef_flat[{reg_wdata[18:16], 4'h0} +: 16] <= reg_wdata[15:0];
            default: begin
               if (reg_addr[5:4] == `REG_LINK_HI)
                  link_mem[reg_addr[3:2]] <= reg_wdata;
            end
         endcase
      end
   end

   // Register reads; data stand only in the cycle after the strobe.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `REG_CTRL: reg_rdata <= {28'h000_0000, fmt16, trans, src};
            `REG_TUNE: reg_rdata <= tune;
            `REG_DEC1: reg_rdata <= {23'h00_0000, {1'b0, dec1_m1} + 9'h001};
            `REG_DEC2: reg_rdata <= {23'h00_0000, {1'b0, dec2_m1} + 9'h001};
            `REG_STAT: reg_rdata <= {{(15-BANK_AW){1'b0}}, fill, 12'h000,
               grec, cap_done, (dstate != D_IDLE), ovf};
            `REG_TIME: reg_rdata <= ts;
            default: begin
               if (reg_addr[5:4] == `REG_LINK_HI)
                  reg_rdata <= link_mem[reg_addr[3:2]];
               else
                  reg_rdata <= 32'h0000_0000;
            end
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // Timing bus pins pass two flip-flops.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         adc0_meta <= {ADC_W{1'b0}};
         adc0_sync <= {ADC_W{1'b0}};
         adc1_meta <= {ADC_W{1'b0}};
         adc1_sync <= {ADC_W{1'b0}};
         gate_meta <= 1'b0;
         gate_sync <= 1'b0;
         gate_d <= 1'b0;
         sync_meta <= 1'b0;
         sync_sync <= 1'b0;
         sync_d <= 1'b0;
         gate_fall_d <= 1'b0;
         ts <= 32'h0000_0000;
         test_cnt <= {ADC_W{1'b0}};
      end else begin
         adc0_meta <= adc0_data;
         adc0_sync <= adc0_meta;
         adc1_meta <= adc1_data;
         adc1_sync <= adc1_meta;
         gate_meta <= tb_gate;
         gate_sync <= gate_meta;
         gate_d <= gate_sync;
         sync_meta <= tb_sync;
         sync_sync <= sync_meta;
         sync_d <= sync_sync;
         gate_fall_d <= gate_fall;
         // Sample-accurate time stamp restarts on each rising sync edge.
         ts <= (sync_sync && !sync_d) ? 32'h0000_0000 : ts + 32'h0000_0001;
         test_cnt <= test_cnt + {{(ADC_W-1){1'b0}}, 1'b1};
      end
   end

   assign gate_rise = gate_sync && !gate_d;
   assign gate_fall = !gate_sync && gate_d;

   always @(posedge core_clk) begin
      if (!rst_n) begin
         sample <= {ADC_W{1'b0}};
      end else begin
         case (src)
            `SRC_ADC0: sample <= adc0_sync;
            `SRC_ADC1: sample <= adc1_sync;
            `SRC_TEST: sample <= test_cnt;
            default: sample <= loop_data;
         endcase
      end
   end

   assign samp_ext = {sample, {(24-ADC_W){1'b0}}};

   always @(posedge core_clk) begin
      if (!rst_n) begin
         nco_phase <= 32'h0000_0000;
         mix_i <= 24'h00_0000;
         mix_q <= 24'h00_0000;
      end else begin
         nco_phase <= nco_phase + tune;
         case (nco_phase[31:30])
            2'h0: begin
               mix_i <= samp_ext;
               mix_q <= 24'h00_0000;
            end
            2'h1: begin
               mix_i <= 24'h00_0000;
               mix_q <= -samp_ext;
            end
            2'h2: begin
               mix_i <= -samp_ext;
               mix_q <= 24'h00_0000;
            end
            default: begin
               mix_i <= 24'h00_0000;
               mix_q <= samp_ext;
            end
         endcase
      end
   end

   // Weighted stage, plain stage, fixed 2x stage.
   dec_stage #(.W(24)) stage1 (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(1'b1),
      .in_i(mix_i),
      .in_q(mix_q),
      .factor_m1(dec1_m1),
      .coef(coef_flat[{s1_phase[2:0], 4'h0} +: 16]),
      .out_valid(s1_valid),
      .out_i(s1_i),
      .out_q(s1_q),
      .phase(s1_phase)
   );

   dec_stage #(.W(24)) stage2 (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(s1_valid),
      .in_i(s1_i),
      .in_q(s1_q),
      .factor_m1(dec2_m1),
      .coef(`COEF_UNITY),
      .out_valid(s2_valid),
      .out_i(s2_i),
      .out_q(s2_q),
      .phase()
   );

   // Complex output at the decimated rate.
   dec_stage #(.W(24)) stage3 (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(s2_valid),
      .in_i(s2_i),
      .in_q(s2_q),
      .factor_m1(`DEC_FIXED_M1),
      .coef(`COEF_UNITY),
      .out_valid(ddc_valid),
      .out_i(ddc_i),
      .out_q(ddc_q),
      .phase()
   );

   assign fill = wr_ptr - rd_ptr;
   assign full = (fill == DEPTH);
   assign empty = (fill == {(BANK_AW+1){1'b0}});
   // Transient mode captures only while armed.
   assign cap_en = !trans || cap_open;
   assign w_req = ddc_valid && gate_sync && cap_en;
   // Sixteen-bit pairs pack into one word.
   assign w_word = fmt16 ? {ddc_q[23:8], ddc_i[23:8]} : {{8{ddc_i[23]}}, ddc_i};
   // Writes stop at a full bank.
   assign wr_fire = !arm && !full && (pend || w_req);
   assign bank_wd = pend ? pend_word : w_word;

   always @(posedge core_clk) begin
      if (wr_fire)
         bank[wr_ptr[BANK_AW-1:0]] <= bank_wd;
   end

   // Write side of the bank and capture bookkeeping.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         wr_ptr <= {(BANK_AW+1){1'b0}};
         pend <= 1'b0;
         pend_word <= 32'h0000_0000;
         ovf <= 1'b0;
         cap_open <= 1'b0;
         cap_done <= 1'b0;
      end else if (arm) begin
         wr_ptr <= {(BANK_AW+1){1'b0}};
         pend <= 1'b0;
         ovf <= 1'b0;
         cap_open <= 1'b1;
         cap_done <= 1'b0;
      end else begin
         if (wr_fire) begin
            wr_ptr <= wr_ptr + {{BANK_AW{1'b0}}, 1'b1};
            pend <= !pend && !fmt16;
            if (!pend)
               pend_word <= {{8{ddc_q[23]}}, ddc_q};
         end
         ovf <= (!trans && full && (w_req || pend)) || (ovf && !ovf_clr);
         // One gate or a full bank ends a transient capture.
         if (trans && cap_open && (gate_fall || full)) begin
            cap_open <= 1'b0;
            cap_done <= 1'b1;
         end
      end
   end

   // Bank words written since the gate opened become the transfer length.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         gcount <= 24'h00_0000;
         gts <= 32'h0000_0000;
         grec <= 1'b0;
         grec_len <= 24'h00_0000;
         grec_ts <= 32'h0000_0000;
      end else begin
         if (gate_rise) begin
            gcount <= 24'h00_0000;
            gts <= ts;
         end else if (wr_fire) begin
            gcount <= gcount + 24'h00_0001;
         end
         if (gate_fall_d) begin
            grec <= 1'b1;
            grec_len <= gcount;
            grec_ts <= gts;
         end else if (grec_take || arm) begin
            // An arm discards a stale record so a gate link waits for its own gate.
            grec <= 1'b0;
         end
      end
   end

   assign out_free = !dma_valid || dma_ready;

   always @(posedge core_clk) begin
      if (!rst_n) begin
         dstate <= D_IDLE;
         link_idx <= 2'h0;
         cur_link <= 32'h0000_0000;
         xfer_len <= 24'h00_0000;
         left <= 24'h00_0000;
         meta_ts <= 32'h0000_0000;
         meta_cnt <= 2'h0;
         grec_take <= 1'b0;
         rd_ptr <= {(BANK_AW+1){1'b0}};
         dma_data <= 32'h0000_0000;
         dma_valid <= 1'b0;
         dma_last <= 1'b0;
      end else begin
         grec_take <= 1'b0;
         if (dma_ready) begin
            dma_valid <= 1'b0;
            dma_last <= 1'b0;
         end
         if (arm)
            rd_ptr <= {(BANK_AW+1){1'b0}};
         case (dstate)
            D_IDLE: begin
               link_idx <= 2'h0;
               if (go)
                  dstate <= D_LOAD;
            end
            D_LOAD: begin
               cur_link <= link_mem[link_idx];
               meta_cnt <= 2'h0;
               dstate <= D_WAIT;
            end
            D_WAIT: begin
               // Gate links wait for a closed gate record.
               if (!cur_link[`LINK_GATE] || (grec && !grec_take)) begin
                  xfer_len <= cur_link[`LINK_GATE] ? grec_len : cur_link[`LINK_LEN_HI:0];
                  left <= cur_link[`LINK_GATE] ? grec_len : cur_link[`LINK_LEN_HI:0];
                  meta_ts <= cur_link[`LINK_GATE] ? grec_ts : ts;
                  grec_take <= cur_link[`LINK_GATE];
                  dstate <= cur_link[`LINK_META] ? D_META : D_DATA;
               end
            end
            D_META: begin
               // Metadata goes out ahead of data.
               if (out_free) begin
                  dma_valid <= 1'b1;
                  dma_last <= (meta_cnt == 2'h2) && (xfer_len == 24'h00_0000);
                  meta_cnt <= meta_cnt + 2'h1;
                  // Id, time stamp and length words.
                  case (meta_cnt)
                     2'h0: dma_data <= {`META_MARK, 8'h00, CH_ID};
                     2'h1: dma_data <= meta_ts;
                     default: dma_data <= {8'h00, xfer_len};
                  endcase
                  if (meta_cnt == 2'h2)
                     dstate <= D_DATA;
               end
            end
            D_DATA: begin
               if (left == 24'h00_0000) begin
                  dstate <= D_NEXT;
               // Bank words leave in write order.
               end else if (out_free && !empty) begin
                  dma_valid <= 1'b1;
                  dma_data <= bank[rd_ptr[BANK_AW-1:0]];
                  dma_last <= (left == 24'h00_0001);
                  rd_ptr <= rd_ptr + {{BANK_AW{1'b0}}, 1'b1};
                  left <= left - 24'h00_0001;
               end
            end
            D_NEXT: begin
               link_idx <= cur_link[`LINK_NEXT_LO+1:`LINK_NEXT_LO];
               dstate <= cur_link[`LINK_LAST] ? D_IDLE : D_LOAD;
            end
            default: dstate <= D_IDLE;
         endcase
      end
   end
endmodule // acq_channel
`default_nettype wire

// ===== verif/acq_channel_checker.sv
// Purpose: Port checks of one acquisition channel.
// Assumes: Bound to every acq_channel instance.
// Notes: Total decimation is at least 8, so output pulses are spaced.
`timescale 1ns/100ps
`default_nettype none
`include "acq_regs.vh"
module acq_channel_checker #(
   parameter BANK_AW = 10
) (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Register port
   input wire [5:0] reg_addr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   // Downconverter and stream
   input wire ddc_valid,
   input wire [23:0] ddc_i,
   input wire [23:0] ddc_q,
   input wire [31:0] dma_data,
   input wire dma_valid,
   input wire dma_last,
   input wire dma_ready
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_ddc_gap: assert property (ddc_valid |=> !ddc_valid [*7])
      else $error("output samples closer than eight cycles");
   chk_ddc_hold: assert property (!ddc_valid |-> $stable(ddc_i) && $stable(ddc_q))
      else $error("output sample changed without a pulse");
   chk_dma_hold: assert property (dma_valid && !dma_ready |=>
      dma_valid && $stable(dma_data) && $stable(dma_last))
      else $error("stream word dropped before acceptance");
   chk_last_valid: assert property (dma_last |-> dma_valid)
      else $error("final mark without a word");
   chk_coef_wo: assert property (reg_rd && reg_addr == `REG_COEF |=> reg_rdata == 32'h0)
      else $error("weight register read back");
   chk_dec_range: assert property (reg_rd && (reg_addr == `REG_DEC1 || reg_addr == `REG_DEC2)
      |=> reg_rdata inside {[32'h2:32'h100]})
      else $error("decimation factor out of range");
   chk_ctrl_pulse: assert property (reg_rd && reg_addr == `REG_CTRL |=> reg_rdata[5:4] == 2'h0)
      else $error("start bits read back");
   chk_fill_cap: assert property (reg_rd && reg_addr == `REG_STAT
      |=> reg_rdata[31:16] <= (32'h1 << BANK_AW))
      else $error("bank fill above capacity");
   cov_sample: cover property (ddc_valid);
   cov_last: cover property (dma_valid && dma_ready && dma_last);
   cov_stat: cover property (reg_rd && reg_addr == `REG_STAT);
endmodule // acq_channel_checker
bind acq_channel acq_channel_checker #(.BANK_AW(BANK_AW)) u_acq_channel_checker (.core_clk,
   .rst_n, .reg_addr, .reg_rd, .reg_rdata, .ddc_valid, .ddc_i, .ddc_q, .dma_data,
   .dma_valid, .dma_last, .dma_ready);
`default_nettype wire

// ===== verif/dma_sink.sv
// Purpose: Host side sink of the DMA stream.
// Assumes: A word moves on an edge with valid and ready both high.
// Notes: In slow mode ready is high one cycle in four.
`timescale 1ns/100ps
`default_nettype none
module dma_sink (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Stream
   input wire slow,
   output var logic dma_ready
);
   logic [1:0] cnt;
   always @(posedge core_clk) begin
      cnt <= rst_n ? cnt + 2'h1 : 2'h0;
      dma_ready <= rst_n && (!slow || cnt == 2'h3);
   end
endmodule // dma_sink
`default_nettype wire

// ===== verif/acq_channel_tb.sv
// Purpose: Self-checking bench of one acquisition channel.
// Assumes: A bank of 16 words stands for the full memory.
// Notes: Expected words wait in queues until the outputs produce them.
`timescale 1ns/100ps
`default_nettype none
`include "acq_regs.vh"
module acq_channel_tb;
   localparam logic [65:0] BAD = {33'h1_FFFF_FFFF, 33'bx};
   logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic tb_sync = 1'b0, tb_gate = 1'b0, slow = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [31:0] reg_wdata = 32'h0, c;
   logic [11:0] adc0_data = 12'h000, adc1_data = 12'h000, loop_data = 12'h000;
   wire [31:0] reg_rdata, dma_data;
   wire ddc_valid, dma_valid, dma_last, dma_ready;
   wire [23:0] ddc_i, ddc_q;
   int mismatches = 0, checks = 0, seed = 93, n, d1, d2;
   logic [65:0] rq[$], dq[$];
   always #5 core_clk = ~core_clk;
   acq_channel #(.CH_ID(16'h5A3C), .BANK_AW(4)) u_acq_channel (.core_clk, .rst_n, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .adc0_data, .adc1_data, .loop_data, .tb_sync,
      .tb_gate, .ddc_valid, .ddc_i, .ddc_q, .dma_data, .dma_valid, .dma_last, .dma_ready);
   dma_sink u_dma_sink (.core_clk, .rst_n, .slow, .dma_ready);
   task automatic check(input logic [32:0] got, input logic [65:0] e);
      checks++;
      if (((got ^ e[32:0]) & e[65:33]) !== 33'h0) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, e[32:0]);
      end
   endtask
   always @(posedge core_clk) begin
      adc0_data <= 12'($random(seed));
      adc1_data <= 12'($random(seed));
      loop_data <= 12'($random(seed));
      rd_d <= reg_rd;
      if (rd_d) check({1'b0, reg_rdata}, rq.size() ? rq.pop_front() : BAD);
      if (dma_valid === 1'b1 && dma_ready === 1'b1)
         check({dma_last, dma_data}, dq.size() ? dq.pop_front() : BAD);
   end
   task wrap_up;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task timeout;
      mismatches++;
      $display("unexpected at %0t: wait ran out", $time);
      wrap_up;
   endtask
   task wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      rq.push_back({1'b0, m, 1'b0, e});
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask
   // Leaves n at the cycles since the previous call.
   task pulse;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (ddc_valid !== 1'b1 && n < 3000);
      if (n >= 3000) timeout();
   endtask
   task dma_run(input bit gd, input bit f16, input int k);
      logic [23:0] len;
      logic [31:0] cw;
      len = 24'(f16 ? k : 2 * k);
      cw = {28'h0, f16, 1'b0, 2'($random(seed))};
      wr(`REG_CTRL, cw | 32'h20);
      wr(6'h20, {5'h0, 2'h3, gd, gd ? 24'h0 : len});
      wr(`REG_CTRL, cw | 32'h10);
      dq.push_back({33'h1_FFFF_FFFF, 33'h0_A500_5A3C});
      dq.push_back({33'h1_0000_0000, 33'h0});
      dq.push_back({33'h1_FFFF_FFFF, 9'h0, len});
      for (int i = 0; i < len; i++)
         dq.push_back({33'h1_0000_0000, i == len - 1, 32'h0});
      slow <= 1'($random(seed));
      pulse;
      tb_gate <= 1'b1;
      repeat (k) pulse;
      tb_gate <= 1'b0;
      n = 0;
      while (dq.size() && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 3000) timeout();
      rd(`REG_CTRL, cw, 32'hFFFF_FFFF);
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      tb_sync <= 1'b1;
      @(posedge core_clk);
      tb_sync <= 1'b0;
      rd(`REG_CTRL, 32'h0, 32'hFFFF_FFFF);
      rd(`REG_DEC1, 32'h2, 32'hFFFF_FFFF);
      rd(6'h34, 32'h0, 32'hFFFF_FFFF);
      wr(`REG_COEF, 32'h0007_4000);
      rd(`REG_COEF, 32'h0, 32'hFFFF_FFFF);
      c = $random(seed);
      wr(`REG_TUNE, c);
      rd(`REG_TUNE, c, 32'hFFFF_FFFF);
      wr(`REG_DEC1, 32'h1);
      rd(`REG_DEC1, 32'h2, 32'hFFFF_FFFF);
      wr(`REG_DEC2, 32'h12C);
      rd(`REG_DEC2, 32'h100, 32'hFFFF_FFFF);
      repeat (3) begin
         d1 = 2 + {$random(seed)} % 4;
         d2 = 2 + {$random(seed)} % 4;
         wr(`REG_DEC1, d1);
         wr(`REG_DEC2, d2);
         repeat (3) pulse;
         check({1'b0, n[31:0]}, {33'h1_FFFF_FFFF, 33'(d1 * d2 * 2)});
      end
      wr(`REG_DEC1, 32'h2);
      wr(`REG_DEC2, 32'h2);
      for (int m = 0; m < 2; m++) begin
         wr(`REG_CTRL, {28'h0, 1'b1, m[0], 2'h2} | 32'h20);
         repeat (3) pulse;
         rd(`REG_STAT, 32'h0, 32'hFFFF_0000);
         tb_gate <= 1'b1;
         repeat (20) pulse;
         tb_gate <= 1'b0;
         rd(`REG_STAT, {16'h10, 13'h0, m[0], 1'b0, !m[0]}, 32'hFFFF_0005);
      end
      dma_run(1'b0, 1'b1, 3);
      dma_run(1'b0, 1'b0, 2);
      dma_run(1'b1, 1'b1, 4);
      dma_run(1'b1, 1'b0, 3);
      wrap_up;
   end
endmodule // acq_channel_tb
`default_nettype wire
